//--- rtl/tii_pkg.sv
package tii_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 50_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned RACE_US    = 300;
    localparam int unsigned RACE_CYC   = (CLK_HZ / 1_000_000) * RACE_US;
    localparam int unsigned RESP_US    = 2500;
    localparam int unsigned RESP_CYC   = (CLK_HZ / 1_000_000) * RESP_US;

    // ----------------------------------------------------------------
    // widths, offsets, reset values, status fields
    // ----------------------------------------------------------------
    localparam int unsigned DB_W      = 7;
    localparam int unsigned CNT_W     = 32;
    localparam logic [6:0]  DB_MAX_MS = 7'h64;
    localparam logic [6:0]  DB_RST    = 7'h0A;
    localparam logic        POL_RST   = 1'b1;
    localparam logic        BLKEN_RST = 1'b1;
    localparam logic [7:0]  OFS_POL   = 8'h00;
    localparam logic [7:0]  OFS_BLKEN = 8'h04;
    localparam logic [7:0]  OFS_DB    = 8'h08;
    localparam logic [7:0]  OFS_STAT  = 8'h20;
    localparam int unsigned ST_BLK    = 0;
    localparam int unsigned ST_SUP    = 1;
    localparam int unsigned ST_TX     = 2;
    localparam int unsigned ST_PA     = 3;
    localparam int unsigned ST_EMERG  = 4;

    typedef enum logic [2:0] {
        TII_IDLE,
        TII_RACE,
        TII_TX_TALK,
        TII_TX_OTHER,
        TII_TX_EMERG
    } tii_mode_t;

    typedef struct packed {
        logic             level;
        logic [CNT_W-1:0] cnt;
    } tii_db_state_t;

endpackage

//--- rtl/tii_line_if.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// one input line: raw pin, its setup, its filtered level
// ----------------------------------------------------------------
interface tii_line_if;
    logic                        raw;
    logic                        pol;
    logic [tii_pkg::DB_W-1:0]    db_ms;
    logic                        level;

    modport owner (output raw, output pol, output db_ms, input level);
    modport filt  (input raw, input pol, input db_ms, output level);
endinterface
`default_nettype wire

//--- rtl/tii_debounce.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// polarity correction and debounce of one line
// ----------------------------------------------------------------
module tii_debounce #(
    parameter int unsigned CYC_PER_MS = tii_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // the filtered line
    tii_line_if.filt  ln
);
    tii_pkg::tii_db_state_t       s_reg;
    tii_pkg::tii_db_state_t       s_next;
    logic                         corr;
    logic [tii_pkg::CNT_W-1:0]    limit;
    logic [tii_pkg::CNT_W-1:0]    cnt_inc;

    // level counts only after it held for the whole time
    always_comb
    begin
        corr    = ln.pol ? ln.raw : ~ln.raw;
        limit   = 32'(ln.db_ms) * 32'(CYC_PER_MS);
        cnt_inc = s_reg.cnt + 32'h0000_0001;
        s_next  = s_reg;
        if (corr == s_reg.level)
        begin
            s_next.cnt = '0;        // a glitch restarts the wait
        end
        else if (cnt_inc >= limit)
        begin
            s_next.level = corr;
            s_next.cnt   = '0;
        end
        else
        begin
            s_next.cnt = cnt_inc;
        end
    end

    // reset takes the present level, so a line live at power-up
    // never shows a fresh assertion and stays unarmed upstream
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            s_reg <= '{level: corr, cnt: '0};
        else
            s_reg <= s_next;
    end

    assign ln.level = s_reg.level;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_zero_db_follows: assert property (@(posedge sys_clk) disable iff (reset)
        (ln.db_ms == 7'h00 && corr != s_reg.level) |=> ln.level == $past(corr))
        else $error("line did not follow with zero debounce");

    a_no_early_flip: assert property (@(posedge sys_clk) disable iff (reset)
        (corr != s_reg.level && cnt_inc < limit) |=> $stable(ln.level))
        else $error("line flipped before debounce time");
endmodule
`default_nettype wire

//--- rtl/tii_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// transmit inhibit inputs: talk block and radiated power suppress
// ----------------------------------------------------------------
module tii_top #(
    parameter int unsigned NSUP        = 2,
    parameter int unsigned NSRC        = 2,
    parameter int unsigned CYC_PER_MS  = tii_pkg::CYC_PER_MS,
    parameter int unsigned RACE_CYCLES = tii_pkg::RACE_CYC
) (
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            reset,
    // register port
    input  wire logic [7:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [31:0]          reg_rdata,
    // inhibit lines from outside equipment
    input  wire logic            talk_request_block_input,
    input  wire logic [NSUP-1:0] radiated_power_suppress_input,
    // transmit requests inside the radio
    input  wire logic [NSRC-1:0] talk_src_req,
    input  wire logic            other_tx_req,
    input  wire logic            emerg_req,
    // transmitter control
    output logic                 tx_on,
    output logic                 pa_ramp_up,
    output logic                 alert_tone
);
    localparam int unsigned NL = NSUP + 1;
    localparam int unsigned SW = (NSRC > 1) ? $clog2(NSRC) : 1;

    typedef struct packed {
        tii_pkg::tii_mode_t                 mode;
        logic [NL-1:0]                      pol;
        logic [NSRC-1:0]                    blk_en;
        logic [NL-1:0][tii_pkg::DB_W-1:0]   db_ms;
        logic [NL-1:0]                      armed;
        logic                               inh_prev;
        logic [NSRC-1:0]                    src_prev;
        logic                               other_prev;
        logic [SW-1:0]                      src;
        logic [31:0]                        race_cnt;
        logic                               tx_on;
        logic                               pa;
        logic                               tone;
        logic [31:0]                        rdata;
    } tii_top_state_t;

    localparam tii_top_state_t RST_STATE = '{
        mode:       tii_pkg::TII_IDLE,
        pol:        {NL{tii_pkg::POL_RST}},
        blk_en:     {NSRC{tii_pkg::BLKEN_RST}},
        db_ms:      {NL{tii_pkg::DB_RST}},
        armed:      '0,
        inh_prev:   1'b0,
        src_prev:   '0,
        other_prev: 1'b0,
        src:        '0,
        race_cnt:   '0,
        tx_on:      1'b0,
        pa:         1'b0,
        tone:       1'b0,
        rdata:      '0
    };

    tii_top_state_t  s_reg;
    tii_top_state_t  s_next;
    logic [NL-1:0]   lvl;
    logic [NL-1:0]   eff;
    logic            blk_eff;
    logic            sup_any;
    logic            inh_any;
    logic            inh_rise;
    logic [NSRC-1:0] rise;
    logic            other_rise;
    logic [SW-1:0]   first_src;
    logic            in_tx_next;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    // debounce register index for an address, NL when unmapped
    function automatic int unsigned db_index(input logic [7:0] a);
        int unsigned k;
        k = NL;
        for (int unsigned i = 0; i < NL; i++)
        begin
            if (a == tii_pkg::OFS_DB + 8'(4 * i))
                k = i;
        end
        return k;
    endfunction

    // lowest numbered source wins a simultaneous press
    function automatic logic [SW-1:0] lowest_set(input logic [NSRC-1:0] v);
        logic [SW-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
                r = SW'(i);
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // input lines
    // ----------------------------------------------------------------
    tii_line_if ln [NL] ();

    // one filter per line, line 0 is the talk block
    generate
        for (genvar g = 0; g < NL; g++)
        begin : g_line
            if (g == 0)
            begin : g_blk
                assign ln[g].raw = talk_request_block_input;
            end
            else
            begin : g_sup
                assign ln[g].raw = radiated_power_suppress_input[g-1];
            end
            assign ln[g].pol   = s_reg.pol[g];
            assign ln[g].db_ms = s_reg.db_ms[g];
            assign lvl[g]      = ln[g].level;
            tii_debounce #(
                .CYC_PER_MS (CYC_PER_MS)
            ) u_db (
                .sys_clk (sys_clk),
                .reset   (reset),
                .ln      (ln[g])
            );
        end
    endgenerate

    // lines live at power-up stay ignored until released once
    assign eff        = lvl & s_reg.armed;
    assign blk_eff    = eff[0];
    assign sup_any    = |eff[NL-1:1];
    assign inh_any    = blk_eff | sup_any;
    assign inh_rise   = inh_any & ~s_reg.inh_prev;
    assign rise       = talk_src_req & ~s_reg.src_prev;
    assign other_rise = other_tx_req & ~s_reg.other_prev;
    assign first_src  = lowest_set(rise);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_next            = s_reg;
        s_next.armed      = s_reg.armed | ~lvl;
        s_next.inh_prev   = inh_any;
        s_next.src_prev   = talk_src_req;
        s_next.other_prev = other_tx_req;
        s_next.tone       = 1'b0;
        s_next.rdata      = '0;

        // transmit sequencing; emergency has priority everywhere
        case (s_reg.mode)
            tii_pkg::TII_IDLE:
            begin
                if (emerg_req)
                    s_next.mode = tii_pkg::TII_TX_EMERG;
                else if (other_rise)
                    s_next.mode = tii_pkg::TII_TX_OTHER;
                else if (|rise)
                begin
                    if (blk_eff && s_reg.blk_en[first_src])
                        s_next.tone = 1'b1;
                    else
                    begin
                        s_next.mode     = tii_pkg::TII_RACE;
                        s_next.src      = first_src;
                        s_next.race_cnt = '0;
                    end
                end
            end
            tii_pkg::TII_RACE:
            begin
                // transmit held back so a late inhibit still wins
                if (emerg_req)
                    s_next.mode = tii_pkg::TII_TX_EMERG;
                else if (inh_rise || !talk_src_req[s_reg.src])
                    s_next.mode = tii_pkg::TII_IDLE;
                else if (s_reg.race_cnt == 32'(RACE_CYCLES - 1))
                    s_next.mode = tii_pkg::TII_TX_TALK;
                else
                    s_next.race_cnt = s_reg.race_cnt + 32'h0000_0001;
            end
            tii_pkg::TII_TX_TALK:
            begin
                if (emerg_req)
                    s_next.mode = tii_pkg::TII_TX_EMERG;
                else if (blk_eff && s_reg.blk_en[s_reg.src])
                    s_next.mode = tii_pkg::TII_IDLE;
                else if (!talk_src_req[s_reg.src])
                    s_next.mode = tii_pkg::TII_IDLE;
            end
            tii_pkg::TII_TX_OTHER:
            begin
                if (emerg_req)
                    s_next.mode = tii_pkg::TII_TX_EMERG;
                else if (!other_tx_req)
                    s_next.mode = tii_pkg::TII_IDLE;
            end
            tii_pkg::TII_TX_EMERG:
            begin
                // back to idle: a held block refuses the next press
                if (!emerg_req)
                    s_next.mode = tii_pkg::TII_IDLE;
            end
            default:
            begin
                s_next.mode = tii_pkg::TII_IDLE;
            end
        endcase

        // suppress touches only the amplifier here; its rise in the race window cancels talk keying unless block or another suppress is already active
        in_tx_next   = (s_next.mode == tii_pkg::TII_TX_TALK)
                     || (s_next.mode == tii_pkg::TII_TX_OTHER)
                     || (s_next.mode == tii_pkg::TII_TX_EMERG);
        s_next.tx_on = in_tx_next;
        // one cycle from filtered level to amplifier, far inside budget
        s_next.pa    = in_tx_next
                     && ((s_next.mode == tii_pkg::TII_TX_EMERG)
                     || !sup_any);

        // register writes; debounce clamps to the longest allowed time
        if (reg_wr)
        begin
            if (reg_addr == tii_pkg::OFS_POL)
                s_next.pol = reg_wdata[NL-1:0];
            else if (reg_addr == tii_pkg::OFS_BLKEN)
                s_next.blk_en = reg_wdata[NSRC-1:0];
            else if (db_index(reg_addr) < NL)
            begin
                if (reg_wdata[31:0] > 32'(tii_pkg::DB_MAX_MS))
                    s_next.db_ms[db_index(reg_addr)] = tii_pkg::DB_MAX_MS;
                else
                    s_next.db_ms[db_index(reg_addr)] = reg_wdata[6:0];
            end
        end

        // register reads, unmapped addresses read zero
        if (reg_rd)
        begin
            if (reg_addr == tii_pkg::OFS_POL)
                s_next.rdata[NL-1:0] = s_reg.pol;
            else if (reg_addr == tii_pkg::OFS_BLKEN)
                s_next.rdata[NSRC-1:0] = s_reg.blk_en;
            else if (db_index(reg_addr) < NL)
                s_next.rdata[6:0] = s_reg.db_ms[db_index(reg_addr)];
            else if (reg_addr == tii_pkg::OFS_STAT)
            begin
                s_next.rdata[tii_pkg::ST_BLK]   = blk_eff;
                s_next.rdata[tii_pkg::ST_SUP]   = sup_any;
                s_next.rdata[tii_pkg::ST_TX]    = s_reg.tx_on;
                s_next.rdata[tii_pkg::ST_PA]    = s_reg.pa;
                s_next.rdata[tii_pkg::ST_EMERG] =
                    (s_reg.mode == tii_pkg::TII_TX_EMERG);
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            s_reg <= RST_STATE;
        else
            s_reg <= s_next;
    end

    // outputs straight from the state register
    assign reg_rdata  = s_reg.rdata;
    assign tx_on      = s_reg.tx_on;
    assign pa_ramp_up = s_reg.pa;
    assign alert_tone = s_reg.tone;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_block_aborts_talk: assert property (
        (s_reg.mode == tii_pkg::TII_TX_TALK && !emerg_req && blk_eff
         && s_reg.blk_en[s_reg.src]) |=> s_reg.mode == tii_pkg::TII_IDLE
         && !tx_on)
        else $error("blocked talk transmit not ended");

    a_unselected_source_free: assert property (
        (s_reg.mode == tii_pkg::TII_TX_TALK && !emerg_req
         && talk_src_req[s_reg.src] && !s_reg.blk_en[s_reg.src])
         |=> s_reg.mode == tii_pkg::TII_TX_TALK)
        else $error("unselected source was blocked");

    a_race_cancels: assert property (
        (s_reg.mode == tii_pkg::TII_RACE && !emerg_req && inh_rise)
         |=> s_reg.mode == tii_pkg::TII_IDLE && !tx_on)
        else $error("talk started despite inhibit in race window");

    a_unarmed_ignored: assert property (
        (s_reg.mode == tii_pkg::TII_TX_OTHER && other_tx_req && !emerg_req
         && (lvl[NL-1:1] & s_reg.armed[NL-1:1]) == '0) |=> pa_ramp_up)
        else $error("line acted on before re-assertion");

    a_other_proceeds: assert property (
        (s_reg.mode == tii_pkg::TII_IDLE && !emerg_req && other_rise)
         |=> s_reg.mode == tii_pkg::TII_TX_OTHER && tx_on)
        else $error("non-talk transmit refused");

    a_emerg_override: assert property (
        (emerg_req && s_reg.mode != tii_pkg::TII_TX_EMERG)
         |=> s_reg.mode == tii_pkg::TII_TX_EMERG && tx_on)
        else $error("emergency did not take over");

    a_emerg_full_power: assert property (
        (s_reg.mode == tii_pkg::TII_TX_EMERG && emerg_req) |=> pa_ramp_up)
        else $error("emergency transmit was suppressed");

    a_suppress_cuts_pa: assert property (
        (s_reg.mode == tii_pkg::TII_TX_OTHER && other_tx_req && !emerg_req
         && sup_any) |=> (!pa_ramp_up && tx_on))
        else $error("power not cut or transmit dropped under suppress");

    a_power_restored: assert property (
        (s_reg.mode == tii_pkg::TII_TX_OTHER && other_tx_req && !emerg_req
         && !sup_any) |=> pa_ramp_up)
        else $error("power not restored after suppress");

    a_exit_free: assert property (
        (s_reg.mode == tii_pkg::TII_TX_OTHER && !other_tx_req && !emerg_req)
         |=> s_reg.mode == tii_pkg::TII_IDLE && !tx_on)
        else $error("transmit exit held back");

    a_tone_cause: assert property (
        alert_tone |-> $past(blk_eff) && !tx_on)
        else $error("alert tone without talk block");
endmodule
`default_nettype wire

//--- sim/tii_ext_equip.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// outside equipment driving the inhibit lines
// ----------------------------------------------------------------
module tii_ext_equip (
    // wanted line states, bit0 block line, bits 1..2 suppress lines
    input  wire logic [2:0] want,
    // how each line is wired: 1 = active high
    input  wire logic [2:0] wired_pol,
    // raw pins toward the radio
    output logic [2:0]      raw
);
    // lines are always driven, never floating; a line found active at
    // power-up is dropped and raised again by the bench before use
    assign raw = ~(want ^ wired_pol);
endmodule
`default_nettype wire

//--- sim/test_transmit_inhibit_inputs.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// bench for the transmit inhibit inputs
// ----------------------------------------------------------------
module test_transmit_inhibit_inputs;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0]  want = 3'h2;
    logic [2:0]  wired_pol = 3'h7;
    logic [2:0]  raw;
    logic [1:0]  talk = 2'h0;
    logic        other = 1'b0;
    logic        emerg = 1'b0;
    logic        tx_on;
    logic        pa_ramp_up;
    logic        alert_tone;
    int          err_count = 0;
    int          cmp_count = 0;
    int          alert_cnt = 0;
    int          cyc = 0;

    // short counts keep the run brief: 10 cycles a ms, race of 8
    tii_top #(.CYC_PER_MS(10), .RACE_CYCLES(8)) u_tii_top (
        .sys_clk                       (sys_clk),
        .reset                         (reset),
        .reg_addr                      (reg_addr),
        .reg_wdata                     (reg_wdata),
        .reg_wr                        (reg_wr),
        .reg_rd                        (reg_rd),
        .reg_rdata                     (reg_rdata),
        .talk_request_block_input      (raw[0]),
        .radiated_power_suppress_input (raw[2:1]),
        .talk_src_req                  (talk),
        .other_tx_req                  (other),
        .emerg_req                     (emerg),
        .tx_on                         (tx_on),
        .pa_ramp_up                    (pa_ramp_up),
        .alert_tone                    (alert_tone)
    );

    tii_ext_equip u_tii_ext_equip (
        .want      (want),
        .wired_pol (wired_pol),
        .raw       (raw)
    );

    // ----------------------------------------------------------------
    // clock, tone pulse count, hang guard
    // ----------------------------------------------------------------
    always #10 sys_clk = ~sys_clk;

    // the tone is a one-cycle pulse, so count it rather than poll it
    always @(posedge sys_clk)
    begin
        cyc++;
        if (alert_tone === 1'b1)
            alert_cnt++;
        if (cyc == 5000)
        begin
            err_count++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // waits whole cycles, then steps off the edge to sample
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    // ----------------------------------------------------------------
    // main sequence; suppress line 0 is already active at reset
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rd(8'h00, 32'h7);
        rd(8'h04, 32'h3);
        rd(8'h08, 32'hA);
        wr(8'h08, 32'hFF);
        rd(8'h08, 32'h64);
        rd(8'h40, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h0);
        wr(8'h10, 32'h0);
        @(posedge sys_clk) other <= 1'b1;
        wt(5);
        chk(pa_ramp_up, 1'b1);
        @(posedge sys_clk) want[1] <= 1'b0;
        wt(4);
        @(posedge sys_clk) want[1] <= 1'b1;
        wt(4);
        chk(pa_ramp_up, 1'b0);
        chk(tx_on, 1'b1);
        rd(8'h20, 32'h6);
        @(posedge sys_clk) emerg <= 1'b1;
        wt(4);
        chk(pa_ramp_up, 1'b1);
        @(posedge sys_clk) emerg <= 1'b0;
        wt(4);
        @(posedge sys_clk) other <= 1'b0;
        wt(2);
        @(posedge sys_clk) other <= 1'b1;
        wt(4);
        chk({tx_on, pa_ramp_up}, 2'b10);
        @(posedge sys_clk) want[1] <= 1'b0;
        wt(4);
        chk(pa_ramp_up, 1'b1);
        // line 2 turned active low; its pin idles high from here on
        @(posedge sys_clk) wired_pol <= 3'h3;
        wr(8'h00, 32'h3);
        wt(4);
        chk(pa_ramp_up, 1'b1);
        @(posedge sys_clk) want[2] <= 1'b1;
        wt(4);
        chk(pa_ramp_up, 1'b0);
        @(posedge sys_clk) other <= 1'b0;
        wt(4);
        chk(tx_on, 1'b0);
        @(posedge sys_clk) want[2] <= 1'b0;
        chk(alert_cnt, 0);
        // talk transmit, then the block line cuts it
        @(posedge sys_clk) talk[0] <= 1'b1;
        wt(12);
        chk(tx_on, 1'b1);
        @(posedge sys_clk) want[0] <= 1'b1;
        wt(4);
        chk(tx_on, 1'b0);
        @(posedge sys_clk) talk[0] <= 1'b0;
        wt(2);
        @(posedge sys_clk) talk[0] <= 1'b1;
        wt(12);
        chk({tx_on, alert_cnt[3:0]}, 5'h01);
        @(posedge sys_clk) talk[0] <= 1'b0;
        wr(8'h04, 32'h2);
        @(posedge sys_clk) talk[0] <= 1'b1;
        wt(12);
        chk(tx_on, 1'b1);
        @(posedge sys_clk) talk[0] <= 1'b0;
        wt(4);
        @(posedge sys_clk) other <= 1'b1;
        wt(4);
        chk(tx_on, 1'b1);
        @(posedge sys_clk) other <= 1'b0;
        wr(8'h04, 32'h3);
        @(posedge sys_clk) talk[1] <= 1'b1;
        wt(4);
        @(posedge sys_clk) emerg <= 1'b1;
        wt(4);
        chk(tx_on, 1'b1);
        @(posedge sys_clk) emerg <= 1'b0;
        wt(2);
        @(posedge sys_clk) talk[1] <= 1'b0;
        wt(2);
        @(posedge sys_clk) talk[1] <= 1'b1;
        wt(12);
        chk({tx_on, alert_cnt[3:0]}, 5'h03);
        @(posedge sys_clk) talk[1] <= 1'b0;
        want[0] <= 1'b0;
        wt(4);
        // suppress line rises three cycles into the race window; the
        // block line is idle, so only the race cancel keeps tx off
        @(posedge sys_clk) talk[0] <= 1'b1;
        wt(3);
        @(posedge sys_clk) want[1] <= 1'b1;
        wt(12);
        chk(tx_on, 1'b0);
        // suppress line 0 on a 1 ms filter: a short glitch is ignored
        @(posedge sys_clk) talk[0] <= 1'b0;
        want[1] <= 1'b0;
        wr(8'h0C, 32'h1);
        @(posedge sys_clk) other <= 1'b1;
        wt(4);
        @(posedge sys_clk) want[1] <= 1'b1;
        wt(4);
        @(posedge sys_clk) want[1] <= 1'b0;
        wt(2);
        chk(pa_ramp_up, 1'b1);
        @(posedge sys_clk) want[1] <= 1'b1;
        wt(8);
        chk(pa_ramp_up, 1'b1);
        wt(6);
        chk(pa_ramp_up, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
